// File: inc/atu_pkg.sv
// ------------------------------------------------------------
// autotune sequencer constants
// ------------------------------------------------------------
package atu_pkg;
	localparam int CLK_MHZ = 250;
	localparam int SECOND_US = 1_000_000;
	localparam int SAMPLE_US = 1000;
	localparam int CYC_PER_SEC = SECOND_US * CLK_MHZ;
	localparam int CYC_PER_SAMPLE = SAMPLE_US * CLK_MHZ;
	localparam int DW = 16;

	// ------------------------------------------------------------
	// register byte offsets
	// ------------------------------------------------------------
	localparam logic [5:0] OFS_DISC = 6'h00;
	localparam logic [5:0] OFS_TIMEOUT = 6'h04;
	localparam logic [5:0] OFS_CFG = 6'h08;
	localparam logic [5:0] OFS_STEP = 6'h0C;
	localparam logic [5:0] OFS_ACT = 6'h10;
	localparam logic [5:0] OFS_RESULT = 6'h14;
	localparam logic [5:0] OFS_KP = 6'h18;
	localparam logic [5:0] OFS_TI = 6'h1C;
	localparam logic [5:0] OFS_TD = 6'h20;
	localparam logic [5:0] OFS_IRQ_ST = 6'h24;
	localparam logic [5:0] OFS_IRQ_MASK = 6'h28;
	localparam logic [5:0] OFS_MV = 6'h2C;

	// ------------------------------------------------------------
	// fields and reset values
	// ------------------------------------------------------------
	localparam int MANUAL_BIT = 0;
	localparam int AT_REQ_BIT = 4;
	localparam int PID_BIT = 0;
	localparam int IRQ_DONE = 0;
	localparam int IRQ_FAIL = 1;
	localparam logic [DW-1:0] RST_TIMEOUT = 16'h003C;
	localparam logic [DW-1:0] RST_STEP = 16'h0064;
	localparam logic [DW-1:0] ACT_MAX_DEF = 16'h0FFF;
	localparam logic [31:0] KP_LIMIT = 32'h0000_FFFF;

	// ------------------------------------------------------------
	// result codes
	// ------------------------------------------------------------
	localparam logic [2:0] RES_RUN = 3'h0;
	localparam logic [2:0] RES_OK = 3'h1;
	localparam logic [2:0] RES_CANCEL = 3'h2;
	localparam logic [2:0] RES_RAISE = 3'h3;
	localparam logic [2:0] RES_FIT = 3'h4;
	localparam logic [2:0] RES_DZ = 3'h5;
	localparam logic [2:0] RES_DEAD = 3'h6;
	localparam logic [2:0] RES_RANGE = 3'h7;
	localparam logic [2:0] RES_TIMEOUT = RES_FIT;

	// ------------------------------------------------------------
	// two-point estimation factors, fixed point
	// ------------------------------------------------------------
	localparam int TH_SHIFT = 10;
	localparam logic [9:0] TH28_Q10 = 10'h122;
	localparam logic [9:0] TH63_Q10 = 10'h287;
	localparam logic [4:0] KP_PID_Q4 = 5'h13;
	localparam logic [4:0] KP_PI_Q4 = 5'h0E;
	localparam logic [5:0] TI_PID_Q4 = 6'h20;
	localparam logic [5:0] TI_PI_Q4 = 6'h35;
	localparam logic [5:0] TD_PID_Q4 = 6'h08;

	typedef enum logic [2:0] {
		S_IDLE = 3'b000,
		S_BASE = 3'b001,
		S_REC = 3'b010,
		S_SCAN = 3'b011,
		S_CALC = 3'b100,
		S_DIV = 3'b101
	} atu_state_type;
endpackage

// File: verilog/atu_tick.sv
`timescale 1ns/1ps
// ------------------------------------------------------------
// one-cycle enable every COUNT clocks, restartable
// ------------------------------------------------------------
module atu_tick #(
	parameter int COUNT = 250
) (
	input wire logic clk,
	input wire logic reset_n,
	input wire logic clr,
	output logic tick
);
	typedef struct packed {
		logic [31:0] cnt;
		logic tick;
	} atu_tick_st_type;
	atu_tick_st_type st_q, st_d;

	always_comb begin
		st_d = st_q;
		st_d.tick = 1'b0;
		if (clr) begin
			st_d.cnt = '0;
		end else if (st_q.cnt == 32'(COUNT - 1)) begin
			st_d.cnt = '0;
			st_d.tick = 1'b1;
		end else begin
			st_d.cnt = st_q.cnt + 32'h0000_0001;
		end
	end

	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			st_q <= '0;
		end else begin
			st_q <= st_d;
		end
	end

	assign tick = st_q.tick;
endmodule

// File: verilog/atu_div.sv
`timescale 1ns/1ps
// ------------------------------------------------------------
// serial restoring divider, one quotient bit per clock
// ------------------------------------------------------------
module atu_div #(
	parameter int W = 32
) (
	input wire logic clk,
	input wire logic reset_n,
	input wire logic start,
	input wire logic [W-1:0] num,
	input wire logic [W-1:0] den,
	output logic done,
	output logic dz,
	output logic [W-1:0] quo
);
	localparam int CW = $clog2(W) + 1;
	typedef struct packed {
		logic busy;
		logic done;
		logic dz;
		logic [CW-1:0] cnt;
		logic [W-1:0] rem;
		logic [W-1:0] quo;
		logic [W-1:0] den;
	} atu_div_st_type;
	atu_div_st_type st_q, st_d;

	always_comb begin
		logic [W:0] trial;
		trial = {st_q.rem, st_q.quo[W-1]} - {1'b0, st_q.den};
		st_d = st_q;
		st_d.done = 1'b0;
		if (start) begin
			st_d.dz = (den == '0);
			st_d.done = (den == '0);
			st_d.busy = (den != '0);
			st_d.cnt = CW'(W);
			st_d.rem = '0;
			st_d.quo = num;
			st_d.den = den;
		end else if (st_q.busy) begin
			if (!trial[W]) begin
				st_d.rem = trial[W-1:0];
				st_d.quo = {st_q.quo[W-2:0], 1'b1};
			end else begin
				st_d.rem = {st_q.rem[W-2:0], st_q.quo[W-1]};
				st_d.quo = {st_q.quo[W-2:0], 1'b0};
			end
			st_d.cnt = st_q.cnt - CW'(1);
			if (st_q.cnt == CW'(1)) begin
				st_d.busy = 1'b0;
				st_d.done = 1'b1;
			end
		end
	end

	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			st_q <= '0;
		end else begin
			st_q <= st_d;
		end
	end

	assign done = st_q.done;
	assign dz = st_q.dz;
	assign quo = st_q.quo;
endmodule

// File: verilog/atu_sequencer.sv
`timescale 1ns/1ps
// ------------------------------------------------------------
// Behaviour
// RULE1: each loop has an autotune request bit at bit four of its discrete word.
// RULE2: a run starts only on a 0 to 1 change of the request bit.
// RULE3: a rising request starts a run only while the loop is manual.
// RULE4: clearing the request bit during a run aborts it with a cancel code.
// RULE5: the result code reads 0 while a run is in progress.
// RULE6: a finished run leaves one of result codes 1 to 7.
// RULE7: a run not finished within the programmed seconds is aborted; the code applies no limit when the timeout register is 0.
// RULE8: software selects PI tuning without derivative, or full PID tuning.
// RULE9: a run steps the actuator output and records the measured response.
// RULE10: gains come from the two-point open-loop Ziegler-Nichols estimate.
// RULE11: the operator lets the process settle before requesting a run.
// RULE12: the operator sets the loop to manual before requesting a run.
// RULE13: success writes the gain registers and leaves the loop mode alone.
// ------------------------------------------------------------
module atu_sequencer import atu_pkg::*; #(
	parameter int DEPTH = 64,
	parameter int SEC_CYC = CYC_PER_SEC,
	parameter int SMP_CYC = CYC_PER_SAMPLE,
	parameter logic [DW-1:0] ACT_MAX = ACT_MAX_DEF
) (
	input wire logic CLK_SYS,
	input wire logic RESET_N,
	input wire logic [5:0] ADDRESS,
	input wire logic READ,
	input wire logic WRITE,
	input wire logic [31:0] WRITEDATA,
	input wire logic [3:0] BYTEENABLE,
	output logic [31:0] READDATA,
	output logic WAITREQUEST,
	input wire logic [DW-1:0] MEASURED_VALUE,
	output logic [DW-1:0] ACTUATOR_OUTPUT,
	output logic IRQ
);
	localparam int IW = $clog2(DEPTH);

	typedef struct packed {
		atu_state_type st;
		logic manual;
		logic req;
		logic req_prev;
		logic pid;
		logic [DW-1:0] timeout;
		logic [DW-1:0] step;
		logic [DW-1:0] act;
		logic [DW-1:0] kp;
		logic [DW-1:0] ti;
		logic [DW-1:0] td;
		logic [DW-1:0] secs;
		logic [DW-1:0] y0;
		logic [DW-1:0] out;
		logic [2:0] result;
		logic [1:0] irq_st;
		logic [1:0] irq_mask;
		logic irq;
		logic ack;
		logic [31:0] rdata;
		logic [IW-1:0] idx;
		logic [IW-1:0] t28;
		logic [IW-1:0] t63;
		logic f28;
		logic f63;
		logic div_go;
		logic [DEPTH-1:0][DW-1:0] mem;
	} atu_regs_type;

	atu_regs_type st_q, st_d;
	logic busy, acc, start, fin, sec_tick, smp_tick, div_done, div_dz, fall, theta_neg;
	logic [2:0] code;
	logic [31:0] rd_mux, quo, num, den, p28, p63;
	logic [DW-1:0] last, dy, th28, th63, sample;
	logic [IW-1:0] dt;
	logic [IW+1:0] tri3, theta;
	logic [IW:0] tau;

	function automatic logic [DW-1:0] wmerge(
		input logic [DW-1:0] old,
		input logic [DW-1:0] wd,
		input logic [1:0] be
	);
		wmerge = {be[1] ? wd[15:8] : old[15:8], be[0] ? wd[7:0] : old[7:0]};
	endfunction

	// ------------------------------------------------------------
	// timebases and divider
	// ------------------------------------------------------------
	atu_tick #(.COUNT(SEC_CYC)) u_sec (
		.clk(CLK_SYS),
		.reset_n(RESET_N),
		.clr(start),
		.tick(sec_tick)
	);

	atu_tick #(.COUNT(SMP_CYC)) u_smp (
		.clk(CLK_SYS),
		.reset_n(RESET_N),
		.clr(start),
		.tick(smp_tick)
	);

	atu_div #(.W(32)) u_div (
		.clk(CLK_SYS),
		.reset_n(RESET_N),
		.start(st_q.div_go),
		.num(num),
		.den(den),
		.done(div_done),
		.dz(div_dz),
		.quo(quo)
	);

	// ------------------------------------------------------------
	// response analysis
	// ------------------------------------------------------------
	// the last recorded sample stands in for the settled value, so the
	// record window must cover the whole rise of the process
	assign last = st_q.mem[DEPTH-1];
	assign dy = last - st_q.y0;
	assign fall = last < st_q.y0;
	assign p28 = 32'(dy) * 32'(TH28_Q10);
	assign p63 = 32'(dy) * 32'(TH63_Q10);
	assign th28 = st_q.y0 + p28[DW+TH_SHIFT-1:TH_SHIFT]; // [RULE10]
	assign th63 = st_q.y0 + p63[DW+TH_SHIFT-1:TH_SHIFT]; // [RULE10]
	assign dt = st_q.t63 - st_q.t28;
	assign tri3 = {2'b00, dt} + {1'b0, dt, 1'b0};
	assign tau = tri3[IW+1:1];
	assign theta = {2'b00, st_q.t63} - {1'b0, tau}; // [RULE10]
	assign theta_neg = theta[IW+1];
	// operands widened first so the products cannot wrap at operand width
	assign num = 32'(st_q.pid ? KP_PID_Q4 : KP_PI_Q4) * 32'(tau) * 32'(st_q.step); // [RULE10]
	assign den = 32'(dy) * 32'(theta);
	assign sample = st_q.mem[st_q.idx];

	// ------------------------------------------------------------
	// bus slave: one wait state, read data registered
	// ------------------------------------------------------------
	assign busy = READ | WRITE;
	assign acc = busy & st_q.ack;
	assign start = (st_q.st == S_IDLE) & st_q.req & ~st_q.req_prev & st_q.manual; // [RULE2] [RULE3]

	always_comb begin
		rd_mux = '0;
		case (ADDRESS)
			OFS_DISC: begin
				rd_mux[MANUAL_BIT] = st_q.manual;
				rd_mux[AT_REQ_BIT] = st_q.req;
			end
			OFS_TIMEOUT: rd_mux[DW-1:0] = st_q.timeout;
			OFS_CFG: rd_mux[PID_BIT] = st_q.pid;
			OFS_STEP: rd_mux[DW-1:0] = st_q.step;
			OFS_ACT: rd_mux[DW-1:0] = st_q.act;
			OFS_RESULT: rd_mux[2:0] = st_q.result;
			OFS_KP: rd_mux[DW-1:0] = st_q.kp;
			OFS_TI: rd_mux[DW-1:0] = st_q.ti;
			OFS_TD: rd_mux[DW-1:0] = st_q.td;
			OFS_IRQ_ST: rd_mux[1:0] = st_q.irq_st;
			OFS_IRQ_MASK: rd_mux[1:0] = st_q.irq_mask;
			OFS_MV: rd_mux[DW-1:0] = MEASURED_VALUE;
			default: rd_mux = '0;
		endcase
	end

	// ------------------------------------------------------------
	// next state
	// ------------------------------------------------------------
	always_comb begin
		st_d = st_q;
		fin = 1'b0;
		code = RES_RUN;
		st_d.div_go = 1'b0;
		st_d.req_prev = st_q.req;
		st_d.ack = busy & ~st_q.ack;
		if (READ & ~st_q.ack) begin
			st_d.rdata = rd_mux;
		end
		if (acc & WRITE) begin
			case (ADDRESS)
				OFS_DISC: begin
					if (BYTEENABLE[0]) begin
						st_d.manual = WRITEDATA[MANUAL_BIT];
						st_d.req = WRITEDATA[AT_REQ_BIT]; // [RULE1]
					end
				end
				OFS_TIMEOUT: st_d.timeout = wmerge(st_q.timeout, WRITEDATA[15:0], BYTEENABLE[1:0]);
				OFS_CFG: begin
					if (BYTEENABLE[0]) begin
						st_d.pid = WRITEDATA[PID_BIT]; // [RULE8]
					end
				end
				OFS_STEP: st_d.step = wmerge(st_q.step, WRITEDATA[15:0], BYTEENABLE[1:0]);
				OFS_ACT: st_d.act = wmerge(st_q.act, WRITEDATA[15:0], BYTEENABLE[1:0]);
				OFS_KP: st_d.kp = wmerge(st_q.kp, WRITEDATA[15:0], BYTEENABLE[1:0]);
				OFS_TI: st_d.ti = wmerge(st_q.ti, WRITEDATA[15:0], BYTEENABLE[1:0]);
				OFS_TD: st_d.td = wmerge(st_q.td, WRITEDATA[15:0], BYTEENABLE[1:0]);
				OFS_IRQ_MASK: begin
					if (BYTEENABLE[0]) begin
						st_d.irq_mask = WRITEDATA[1:0];
					end
				end
				default: ;
			endcase
		end
		// clear only the bits that the read returned; a later event survives
		if (acc & READ & (ADDRESS == OFS_IRQ_ST)) begin
			st_d.irq_st = st_q.irq_st & ~st_q.rdata[1:0];
		end

		case (st_q.st)
			S_IDLE: begin
				st_d.out = st_q.act;
				if (start) begin
					st_d.st = S_BASE;
					st_d.result = RES_RUN; // [RULE5]
					st_d.secs = '0;
					st_d.idx = '0;
					st_d.f28 = 1'b0;
					st_d.f63 = 1'b0;
				end
			end
			S_BASE: begin
				if (smp_tick) begin
					st_d.y0 = MEASURED_VALUE;
					if ((st_q.step == '0) || ({1'b0, st_q.act} + {1'b0, st_q.step} > {1'b0, ACT_MAX})) begin
						fin = 1'b1;
						code = RES_RAISE; // [RULE6]
					end else begin
						st_d.out = st_q.act + st_q.step; // [RULE9]
						st_d.st = S_REC;
					end
				end
			end
			S_REC: begin
				if (smp_tick) begin
					st_d.mem[st_q.idx] = MEASURED_VALUE; // [RULE9]
					st_d.idx = st_q.idx + IW'(1);
					if (st_q.idx == IW'(DEPTH - 1)) begin
						st_d.st = S_SCAN;
					end
				end
			end
			S_SCAN: begin
				if (!st_q.f28 && (sample >= th28)) begin
					st_d.f28 = 1'b1;
					st_d.t28 = st_q.idx;
				end
				if (!st_q.f63 && (sample >= th63)) begin
					st_d.f63 = 1'b1;
					st_d.t63 = st_q.idx;
				end
				st_d.idx = st_q.idx + IW'(1);
				if (st_q.idx == IW'(DEPTH - 1)) begin
					st_d.st = S_CALC;
				end
			end
			S_CALC: begin
				if (fall || !st_q.f28 || !st_q.f63 || (st_q.t63 < st_q.t28)) begin
					fin = 1'b1;
					code = RES_FIT; // [RULE6]
				end else if (theta_neg) begin
					fin = 1'b1;
					code = RES_DEAD; // [RULE6]
				end else begin
					st_d.div_go = 1'b1;
					st_d.st = S_DIV;
				end
			end
			S_DIV: begin
				if (div_done) begin
					fin = 1'b1;
					if (div_dz) begin
						code = RES_DZ; // [RULE6]
					end else if ((quo == '0) || (quo > KP_LIMIT)) begin
						code = RES_RANGE; // [RULE6]
					end else begin
						code = RES_OK;
						st_d.kp = quo[DW-1:0]; // [RULE13]
						st_d.ti = DW'(32'(theta) * 32'(st_q.pid ? TI_PID_Q4 : TI_PI_Q4)); // [RULE10]
						st_d.td = st_q.pid ? DW'(32'(theta) * 32'(TD_PID_Q4)) : '0; // [RULE8]
					end
				end
			end
			default: st_d.st = S_IDLE;
		endcase

		if (st_q.st != S_IDLE) begin
			if (sec_tick) begin
				st_d.secs = st_q.secs + DW'(1);
			end
			if (!st_q.req) begin
				fin = 1'b1;
				code = RES_CANCEL; // [RULE4]
			end else if ((st_q.timeout != '0) && (st_q.secs >= st_q.timeout)) begin
				fin = 1'b1;
				code = RES_TIMEOUT; // [RULE7]
			end
		end
		// the loop mode bit is never touched here
		if (fin) begin
			st_d.st = S_IDLE;
			st_d.result = code; // [RULE6]
			st_d.out = st_q.act;
			st_d.irq_st[IRQ_DONE] = 1'b1;
			if (code != RES_OK) begin
				st_d.irq_st[IRQ_FAIL] = 1'b1;
			end
		end
		st_d.irq = |(st_d.irq_st & st_d.irq_mask);
	end

	always_ff @(posedge CLK_SYS or negedge RESET_N) begin
		if (!RESET_N) begin
			st_q <= '0;
			st_q.timeout <= RST_TIMEOUT;
			st_q.step <= RST_STEP;
		end else begin
			st_q <= st_d;
		end
	end

	assign READDATA = st_q.rdata;
	assign WAITREQUEST = busy & ~st_q.ack;
	assign ACTUATOR_OUTPUT = st_q.out;
	assign IRQ = st_q.irq;

	// ------------------------------------------------------------
	// checks
	// ------------------------------------------------------------
	default clocking cb @(posedge CLK_SYS); endclocking
	default disable iff (!RESET_N);

	sequence s_run_end;
		(st_q.st != S_IDLE) ##1 (st_q.st == S_IDLE);
	endsequence

	sequence s_run_begin;
		(st_q.st == S_IDLE) ##1 (st_q.st == S_BASE);
	endsequence

	a_req_bit: assert property ((acc && WRITE && (ADDRESS == OFS_DISC) && BYTEENABLE[0]) // [RULE1]
		|=> st_q.req == $past(WRITEDATA[AT_REQ_BIT]))
		else $error("request bit not at its position");
	a_start_edge: assert property (s_run_begin // [RULE2] [RULE3]
		|-> $past(st_q.manual) && $past(st_q.req) && !$past(st_q.req_prev))
		else $error("run started without manual rising request");
	a_level_hold: assert property ((st_q.st == S_IDLE) && st_q.req_prev // [RULE2]
		|=> st_q.st == S_IDLE)
		else $error("steady request started a run");
	a_cancel_code: assert property ((st_q.st != S_IDLE) && !st_q.req // [RULE4]
		|=> (st_q.st == S_IDLE) && (st_q.result == RES_CANCEL))
		else $error("cancel not reported");
	a_result_busy: assert property ((st_q.st != S_IDLE) |-> st_q.result == RES_RUN) // [RULE5]
		else $error("result not zero during run");
	a_end_code: assert property (s_run_end |-> st_q.result != RES_RUN) // [RULE6]
		else $error("run ended without code");
	a_time_limit: assert property ((st_q.st != S_IDLE) && st_q.req && (st_q.timeout != '0) // [RULE7]
		&& (st_q.secs >= st_q.timeout) |=> st_q.result == RES_TIMEOUT)
		else $error("time limit not enforced");
	a_pi_no_rate: assert property ((s_run_end ##0 (st_q.result == RES_OK) && !st_q.pid) // [RULE8]
		|-> st_q.td == '0)
		else $error("derivative in PI tuning");
	a_step_out: assert property ((st_q.st == S_BASE) ##1 (st_q.st == S_REC) // [RULE9]
		|-> ACTUATOR_OUTPUT == DW'($past(st_q.act) + $past(st_q.step)))
		else $error("step not applied");
	a_zn_ratio: assert property ((s_run_end ##0 (st_q.result == RES_OK) && st_q.pid) // [RULE10]
		|-> st_q.ti == DW'(st_q.td << 2))
		else $error("integral and derivative times disagree");
	a_gain_load: assert property ((s_run_end ##0 st_q.result == RES_OK) |-> st_q.kp != '0) // [RULE13]
		else $error("gain not written on success");
	a_wait_one: assert property (busy && WAITREQUEST |=> !WAITREQUEST)
		else $error("wait state longer than one cycle");
endmodule

// File: bench/atu_plant_model.sv
`timescale 1ns/1ps
// ------------------------------------------------------------
// plant: dead time, optional jump, then a linear ramp to a new level
// ------------------------------------------------------------
module atu_plant_model import atu_pkg::*; (
	input wire logic clk,
	input wire logic reset_n,
	input wire logic [DW-1:0] act,
	input wire logic [6:0] jump_pct,
	input wire logic [7:0] dead,
	output logic [DW-1:0] mv
);
	localparam int RAMP = 160;
	localparam int BIAS = 300;
	logic [DW-1:0] act_prev;
	int from_v;
	int to_v;
	int cnt;
	int d;
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			act_prev <= '0;
			cnt <= 1000;
			from_v <= BIAS;
			to_v <= BIAS;
		end else begin
			act_prev <= act;
			if (act != act_prev) begin
				// restart from where the output stands, not from the old target
				from_v <= int'(mv);
				to_v <= BIAS + int'(act) / 2;
				cnt <= 0;
			end else if (cnt < 1000) begin
				cnt <= cnt + 1;
			end
		end
	end
	// output holds still once the ramp is over, so the bench can settle it
	always_comb begin
		d = to_v - from_v;
		if (cnt < int'(dead)) begin
			mv = DW'(from_v);
		end else if (cnt - int'(dead) >= RAMP) begin
			mv = DW'(to_v);
		end else begin
			mv = DW'(from_v + d * int'(jump_pct) / 100
				+ d * (100 - int'(jump_pct)) * (cnt - int'(dead)) / (100 * RAMP));
		end
	end
endmodule

// File: bench/tb_top.sv
`timescale 1ns/1ps
`define CHK(nm, e, g) begin total_checks++; if ((g) !== (e)) begin err_count++; \
	$display("Error %s expected %h seen %h", nm, e, g); end end
module tb_top import atu_pkg::*;;
	localparam int SMP = 8;
	logic clk = 1'b0;
	logic rst_n = 1'b0;
	logic [5:0] addr = '0;
	logic rd = 1'b0;
	logic wr = 1'b0;
	logic [31:0] wdata = '0;
	logic [31:0] rdata;
	logic [31:0] q;
	logic waitreq;
	logic irq;
	logic [DW-1:0] mv;
	logic [DW-1:0] act_out;
	logic [6:0] jump_pct = '0;
	logic [7:0] dead = 8'h28;
	logic [15:0] lfsr_q = 16'h003A;
	int err_count = 0;
	int total_checks = 0;

	atu_sequencer #(.DEPTH(32), .SEC_CYC(200), .SMP_CYC(SMP), .ACT_MAX(ACT_MAX_DEF)) dut (
		.CLK_SYS(clk), .RESET_N(rst_n), .ADDRESS(addr), .READ(rd), .WRITE(wr),
		.WRITEDATA(wdata), .BYTEENABLE(4'hF), .READDATA(rdata), .WAITREQUEST(waitreq),
		.MEASURED_VALUE(mv), .ACTUATOR_OUTPUT(act_out), .IRQ(irq));
	atu_plant_model plant (.clk(clk), .reset_n(rst_n), .act(act_out),
		.jump_pct(jump_pct), .dead(dead), .mv(mv));

	// ------------------------------------------------------------
	// bus cycles, expectations and runs
	// ------------------------------------------------------------
	task automatic bus(input logic w, input logic [5:0] a, input logic [15:0] dv);
		int n;
		@(posedge clk);
		addr <= a;
		wr <= w;
		rd <= !w;
		wdata <= {16'h0000, dv};
		n = 0;
		do begin
			@(posedge clk);
			n++;
		end while (waitreq !== 1'b0 && n < 50);
		if (n >= 50) begin
			err_count++;
			$display("Error bus expected ready seen stuck");
		end
		q = rdata;
		wr <= 1'b0;
		rd <= 1'b0;
	endtask
	task automatic wreg(input logic [5:0] a, input logic [15:0] dv);
		bus(1'b1, a, dv);
	endtask
	task automatic rreg(input logic [5:0] a);
		bus(1'b0, a, 16'h0000);
	endtask
	function automatic logic [15:0] lfsr(input logic [15:0] s);
		return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
	endfunction
	function automatic logic [2:0] exp_code(input int a, input int s, input int jp,
			input int tmo, input int cancel);
		if (cancel != 0) return RES_CANCEL;
		if (s == 0 || a + s > int'(ACT_MAX_DEF)) return RES_RAISE;
		if (tmo == 1) return RES_TIMEOUT;
		if (jp >= 28) return RES_DEAD;
		return RES_OK;
	endfunction
	task automatic run(input string nm, input int a, input int s, input int pid, input int tmo,
			input int jp, input int cancel, input logic [15:0] mask);
		logic [2:0] ec;
		logic [15:0] ti;
		int n;
		ec = exp_code(a, s, jp, tmo, cancel);
		wreg(OFS_ACT, 16'(a));
		wreg(OFS_STEP, 16'(s));
		wreg(OFS_CFG, 16'(pid));
		wreg(OFS_TIMEOUT, 16'(tmo));
		wreg(OFS_IRQ_MASK, mask);
		jump_pct <= 7'(jp);
		dead <= (jp > 0) ? 8'h00 : 8'h28;
		repeat (300) @(posedge clk); // steady plant before the step
		wreg(OFS_DISC, 16'h0001); // manual first
		wreg(OFS_DISC, 16'h0011);
		repeat (2 * SMP + 4) @(posedge clk);
		if (ec != RES_RAISE) begin
			`CHK("step out", 16'(a + s), act_out)
			rreg(OFS_RESULT);
			`CHK("busy code", RES_RUN, q[2:0])
		end
		if (cancel != 0) begin
			repeat (cancel) @(posedge clk);
			wreg(OFS_DISC, 16'h0001);
		end
		n = 0;
		do begin
			rreg(OFS_RESULT);
			n++;
		end while (q[2:0] === RES_RUN && n < 2000);
		`CHK("code", ec, q[2:0])
		`CHK("out back", 16'(a), act_out)
		if (ec == RES_OK) begin
			rreg(OFS_TI);
			ti = q[15:0];
			rreg(OFS_TD);
			if (pid != 0) `CHK("ti 4td", 16'(q[15:0] * 4), ti)
			else `CHK("td pi", 16'h0000, q[15:0])
			if (pid == 0) `CHK("ti pi", 16'h0000, 16'(ti % 53))
			rreg(OFS_KP);
			`CHK("kp set", 1'b1, q[15:0] != 16'h0000)
			rreg(OFS_DISC);
			`CHK("mode kept", 16'h0011, q[15:0])
		end
		`CHK("irq", mask[0] | (mask[1] & (ec != RES_OK)), irq)
		rreg(OFS_IRQ_ST);
		`CHK("ended", 1'b1, q[0])
		`CHK("failed", ec != RES_OK, q[1])
		repeat (2) @(posedge clk);
		`CHK("irq clr", 1'b0, irq)
		$display("test %s done", nm);
	endtask
	task automatic end_of_test();
		$display("checks %0d mismatches %0d", total_checks, err_count);
		if (err_count == 0 && total_checks > 0) begin
			$display("Result: passed");
		end else begin
			$display("Result: failed");
		end
		$finish;
	endtask

	initial begin
		forever #2 clk = ~clk;
	end
	initial begin
		repeat (6) @(posedge clk);
		rst_n <= 1'b1;
	end
	initial begin
		repeat (40000) @(posedge clk);
		err_count++;
		$display("Error watchdog expected finish seen hang");
		end_of_test();
	end
	initial begin
		int a;
		int s;
		@(posedge rst_n);
		rreg(OFS_TIMEOUT);
		`CHK("tmo rst", 16'h003C, q[15:0])
		rreg(OFS_DISC);
		`CHK("disc rst", 16'h0000, q[15:0])
		wreg(OFS_RESULT, 16'h0007);
		rreg(OFS_RESULT);
		`CHK("code ro", 16'h0000, q[15:0])
		wreg(6'h30, 16'hFFFF);
		rreg(6'h30);
		`CHK("unmapped", 32'h0000_0000, q)
		rreg(OFS_MV);
		`CHK("mv live", mv, q[15:0])
		$display("test reset done");
		for (int i = 0; i < 4; i++) begin
			lfsr_q = lfsr(lfsr_q);
			a = int'(lfsr_q[9:0]);
			lfsr_q = lfsr(lfsr_q);
			s = 64 + int'(lfsr_q[8:0]);
			run("random", a, s, i % 2, 60, 0, 0, 16'h0001);
		end
		// launches that must not happen: auto mode, level held, wrong bit
		wreg(OFS_DISC, 16'h0000);
		wreg(OFS_DISC, 16'h0010);
		repeat (40) @(posedge clk);
		rreg(OFS_RESULT);
		`CHK("auto start", RES_OK, q[2:0])
		`CHK("auto out", 16'(a), act_out)
		wreg(OFS_DISC, 16'h0011);
		repeat (40) @(posedge clk);
		rreg(OFS_RESULT);
		`CHK("level start", RES_OK, q[2:0])
		wreg(OFS_DISC, 16'h0001);
		wreg(OFS_DISC, 16'h0009);
		repeat (40) @(posedge clk);
		rreg(OFS_RESULT);
		`CHK("bit3 start", RES_OK, q[2:0])
		$display("test launch done");
		run("cancel", 100, 200, 1, 60, 0, 40, 16'h0001);
		run("timeout", 100, 200, 1, 1, 0, 0, 16'h0001);
		run("no step", 100, 0, 1, 60, 0, 0, 16'h0000);
		run("over range", 4000, 200, 0, 60, 0, 0, 16'h0002);
		run("dead time", 200, 400, 1, 60, 30, 0, 16'h0001);
		end_of_test();
	end
endmodule
